// ---- verilog/adc_cal_pkg.sv ----
package adc_cal_pkg;
  localparam int DATA_W    = 16;
  localparam int CAL_W     = 14;
  localparam int BYTE_W    = 8;
  localparam int NUM_CAL   = 10;
  localparam int PTR_W     = 4;
  localparam int CONV_W    = 12;
  // Control word field positions
  localparam int CTL_PMGT_LO  = 8;
  localparam int CTL_RDSEL_LO = 6;
  localparam int CTL_RANGE    = 5;
  localparam int CTL_CAL_MODE_SELECT    = 3;
  localparam int CTL_CALSEL_LO = 1;
  localparam int CTL_CAL_START_FLAG    = 0;
  // Status word field positions
  localparam int ST_ZERO_LO   = 10;
  localparam int ST_PMGT_LO   = 8;
  localparam int ST_ONES_LO   = 6;
  localparam int ST_RANGE     = 5;
  localparam int ST_BUSY      = 4;
  localparam int ST_CAL_MODE_SELECT     = 3;
  localparam int ST_CALSEL_LO = 1;
  localparam int ST_CAL_START_FLAG     = 0;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [1:0] ONES_PATTERN = 2'h3;
  // Read select codes
  localparam logic [1:0] RDSEL_STATUS = 2'h3;
  localparam logic [1:0] RDSEL_CAL    = 2'h2;
  // Calibration select codes
  localparam logic [1:0] CALSEL_ALL      = 2'h0;
  localparam logic [1:0] CALSEL_GAIN_OFF = 2'h1;
  localparam logic [1:0] CALSEL_OFF_ONLY = 2'h2;
  localparam logic [1:0] CALSEL_GAIN_ONLY = 2'h3;
  // Register indices and last sequence positions
  localparam logic [PTR_W-1:0] IDX_GAIN    = 4'h0;
  localparam logic [PTR_W-1:0] IDX_OFFSET  = 4'h1;
  localparam logic [PTR_W-1:0] LAST_ALL    = 4'h9;
  localparam logic [PTR_W-1:0] LAST_PAIR   = 4'h1;
  localparam logic [PTR_W-1:0] LAST_SINGLE = 4'h0;

  typedef struct packed {
    logic [1:0] power_mode;
    logic [1:0] read_select;
    logic       input_range_select;
    logic       cal_mode_select;
    logic [1:0] cal_select;
  } ctrl_fields_type;

  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic ctrl_sel;
    logic high_byte_enable;
  } bus_req_type;

  localparam ctrl_fields_type CTRL_RESET = '0;
endpackage

// ---- verilog/adc_cal_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_cal_regs
  import adc_cal_pkg::*;
#(
  parameter int NUM_REGS = NUM_CAL
)
(
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire logic              byte_mode_i,
  input  wire bus_req_type       bus_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [CONV_W-1:0] conv_result_i,
  input  wire logic              conv_busy_i,
  input  wire logic              cal_busy_i,
  input  wire logic              engine_wr_i,
  input  wire logic [PTR_W-1:0]  engine_idx_i,
  input  wire logic [CAL_W-1:0]  engine_data_i,
  output logic                   cal_start_o,
  output logic      [2:0]        cal_type_o,
  output logic      [1:0]        power_mode_o,
  output logic                   input_range_o,
  output logic      [PTR_W-1:0]  cal_ptr_o
);

  // Last position of the selected sequence
  function automatic logic [PTR_W-1:0] seq_last(input logic [1:0] sel);
    case (sel)
      CALSEL_ALL:      seq_last = LAST_ALL;
      CALSEL_GAIN_OFF: seq_last = LAST_PAIR;
      default:         seq_last = LAST_SINGLE;
    endcase
  endfunction

  // Storage index from select code and position
  function automatic logic [PTR_W-1:0] cal_index(input logic [1:0] sel,
                                                 input logic [PTR_W-1:0] pos);
    case (sel)
      CALSEL_OFF_ONLY:  cal_index = IDX_OFFSET;
      CALSEL_GAIN_ONLY: cal_index = IDX_GAIN;
      default:          cal_index = pos;
    endcase
  endfunction

  ctrl_fields_type   ctrl_q;
  logic [PTR_W-1:0]  pos_q;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [BYTE_W-1:0] lo_hold_q;
  logic [CAL_W-1:0]  cal_q [NUM_REGS];
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] word_d;
  logic [PTR_W-1:0]  idx;
  logic              ctrl_wr;
  logic              cal_wr;
  logic              data_rd;
  logic              word_done;
  logic              cal_acc_done;
  logic              cal_start_q;

  // Bus decode; pins already synchronous
  assign ctrl_wr   = ce_i && bus_i.cs && bus_i.wr && bus_i.ctrl_sel;
  assign cal_wr    = ce_i && bus_i.cs && bus_i.wr && !bus_i.ctrl_sel;
  assign data_rd   = ce_i && bus_i.cs && bus_i.rd;
  assign word_done = !byte_mode_i || bus_i.high_byte_enable;
  assign cal_acc_done = (cal_wr || (data_rd && ctrl_q.read_select == RDSEL_CAL))
                        && word_done;
  assign idx       = cal_index(ctrl_q.cal_select, pos_q);

  // Control field capture
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      ctrl_q <= CTRL_RESET;
    else if (ctrl_wr)
    begin
      ctrl_q.power_mode         <= wdata_i[CTL_PMGT_LO +: 2];
      ctrl_q.read_select        <= wdata_i[CTL_RDSEL_LO +: 2];
      ctrl_q.input_range_select <= wdata_i[CTL_RANGE];
      ctrl_q.cal_mode_select    <= wdata_i[CTL_CAL_MODE_SELECT];
      ctrl_q.cal_select         <= wdata_i[CTL_CALSEL_LO +: 2];
    end
  end

  // Calibration start pulse with type
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cal_start_q <= 1'b0;
      cal_type_o  <= 3'h0;
    end
    else if (ce_i)
    begin
      cal_start_q <= ctrl_wr && wdata_i[CTL_CAL_START_FLAG];
      if (ctrl_wr && wdata_i[CTL_CAL_START_FLAG])
        cal_type_o <= {wdata_i[CTL_CAL_MODE_SELECT], wdata_i[CTL_CALSEL_LO +: 2]};
    end
  end

  assign cal_start_o   = cal_start_q;
  assign power_mode_o  = ctrl_q.power_mode;
  assign input_range_o = ctrl_q.input_range_select;
  assign cal_ptr_o     = idx;

  // Sequence position, restart and advance
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      pos_q <= IDX_GAIN;
    else if (ctrl_wr)
      pos_q <= IDX_GAIN;
    else if (cal_acc_done)
    begin
      if (pos_q == seq_last(ctrl_q.cal_select))
        pos_q <= IDX_GAIN;
      else
        pos_q <= pos_q + 4'h1;
    end
  end

  // Low byte holding for byte-mode writes
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      lo_hold_q <= '0;
    else if (cal_wr && byte_mode_i && !bus_i.high_byte_enable)
      lo_hold_q <= wdata_i[BYTE_W-1:0];
  end

  // Calibration storage; engine wins over host
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        cal_q[i] <= '0;
    end
    else if (ce_i && engine_wr_i)
      cal_q[engine_idx_i] <= engine_data_i;
    else if (cal_wr && word_done)
    begin
      if (byte_mode_i)
        cal_q[idx] <= {wdata_i[CAL_W-BYTE_W-1:0], lo_hold_q};
      else
        cal_q[idx] <= wdata_i[CAL_W-1:0];
    end
  end

  // Live status word
  always_comb
  begin
    status_d = STATUS_RESET;
    status_d[ST_PMGT_LO +: 2] = ctrl_q.power_mode;
    status_d[ST_ONES_LO +: 2] = ONES_PATTERN;
    status_d[ST_RANGE] = ctrl_q.input_range_select;
    status_d[ST_BUSY]  = conv_busy_i || cal_busy_i;
    status_d[ST_CAL_MODE_SELECT] = ctrl_q.cal_mode_select;
    status_d[ST_CALSEL_LO +: 2] = ctrl_q.cal_select;
    status_d[ST_CAL_START_FLAG] = cal_busy_i;
  end

  // Status resets to zero, then loads the live word each enabled cycle, no write path
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      status_q <= STATUS_RESET;
    else if (ce_i)
      status_q <= status_d;
  end

  // Readback source selection
  always_comb
  begin
    case (ctrl_q.read_select)
      RDSEL_STATUS: word_d = status_q;
      RDSEL_CAL:    word_d = {2'h0, cal_q[idx]};
      default:      word_d = {4'h0, conv_result_i};
    endcase
  end

  // Read data register, byte lanes in low bits
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rdata_q <= '0;
    else if (data_rd)
    begin
      if (!byte_mode_i)
        rdata_q <= word_d;
      else if (bus_i.high_byte_enable)
        rdata_q <= {8'h00, word_d[DATA_W-1:BYTE_W]};
      else
        rdata_q <= {8'h00, word_d[BYTE_W-1:0]};
    end
  end

  assign rdata_o = rdata_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_status_top_zero: assert property (status_q[DATA_W-1:ST_ZERO_LO] == '0)
    else $error("status upper bits not zero");
  a_status_ones: assert property (ce_i |=> status_q[ST_ONES_LO +: 2] == ONES_PATTERN)
    else $error("status ones field wrong");
  a_status_busy: assert property (ce_i |=> status_q[ST_BUSY] == $past(conv_busy_i || cal_busy_i))
    else $error("busy bit does not follow activity");
  a_status_calrun: assert property (ce_i |=> status_q[ST_CAL_START_FLAG] == $past(cal_busy_i))
    else $error("calibration running bit wrong");
  a_ptr_ctrl_reset: assert property (ctrl_wr |=> pos_q == IDX_GAIN)
    else $error("pointer not restarted by control write");
  a_ptr_advance: assert property (
    (!ctrl_wr && cal_acc_done && pos_q != seq_last(ctrl_q.cal_select))
    |=> pos_q == $past(pos_q) + 4'h1)
    else $error("pointer did not advance");
  a_ptr_byte_hold: assert property (
    (!ctrl_wr && byte_mode_i && !bus_i.high_byte_enable) |=> $stable(pos_q))
    else $error("pointer moved on low byte");
  a_offset_only_ptr: assert property (
    ctrl_q.cal_select == CALSEL_OFF_ONLY |-> cal_ptr_o == IDX_OFFSET)
    else $error("offset-only pointer wrong");
  a_cal_read_msbs: assert property (
    (data_rd && !byte_mode_i && ctrl_q.read_select == RDSEL_CAL)
    |=> rdata_o[DATA_W-1:CAL_W] == 2'h0)
    else $error("calibration readback MSBs not zero");
  a_status_readback: assert property (
    (data_rd && !byte_mode_i && ctrl_q.read_select == RDSEL_STATUS)
    |=> rdata_o == $past(status_q))
    else $error("status readback mismatch");
  a_engine_update: assert property (
    (ce_i && engine_wr_i) |=> cal_q[$past(engine_idx_i)] == $past(engine_data_i))
    else $error("engine update lost");

  c_full_wrap: cover property (cal_acc_done && ctrl_q.cal_select == CALSEL_ALL
                               && pos_q == LAST_ALL);
  c_status_read: cover property (data_rd && ctrl_q.read_select == RDSEL_STATUS);
  c_cal_start: cover property (cal_start_o);
  c_byte_write: cover property (cal_wr && byte_mode_i && bus_i.high_byte_enable);

endmodule
`default_nettype wire

// ---- tb/adc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_host_model
  import adc_cal_pkg::*;
(
  input  wire logic              clk_i,
  output bus_req_type            bus_o,
  output logic      [DATA_W-1:0] wdata_o,
  input  wire logic [DATA_W-1:0] rdata_i
);
  initial
  begin
    bus_o = '0;
    wdata_o = 16'h0000;
  end
  // One strobe per transfer, data scrambled once released
  task automatic xfer(input logic w, input logic c, input logic h,
                      input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    @(posedge clk_i);
    bus_o <= '{1'b1, w, !w, c, h};
    wdata_o <= w ? d : ~wdata_o;
    @(posedge clk_i);
    bus_o <= '0;
    wdata_o <= ~d;
    @(posedge clk_i);
    #1 q = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_adc_status_and_cal_register_access.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_adc_status_and_cal_register_access
  import adc_cal_pkg::*;
;
  logic clk = 0, nrst = 0, ce = 1, bm = 0, ewr = 0, cbusy = 0, kbusy = 0;
  logic [11:0]  cres = 12'h000;
  logic [3:0]   eidx = 4'h0, ptr;
  logic [13:0]  edat = 14'h0000;
  logic [15:0]  wd, rdat, q, d;
  logic [2:0]   ctype;
  logic [1:0]   pm_o;
  logic         st_o, rng_o;
  bus_req_type  bus;
  ctrl_fields_type f;
  logic [13:0]  calm [10];
  int err_count = 0, num_checks = 0, starts = 0, n0, k;

  always #2 clk = ~clk;
  // Count start pulses
  always @(posedge clk)
    if (st_o === 1'b1)
      starts <= starts + 1;

  adc_host_model i_adc_host_model (.clk_i(clk), .bus_o(bus), .wdata_o(wd),
    .rdata_i(rdat));
  adc_cal_regs i_adc_cal_regs (.clk_i(clk), .nrst_i(nrst), .ce_i(ce),
    .byte_mode_i(bm), .bus_i(bus), .wdata_i(wd), .rdata_o(rdat),
    .conv_result_i(cres), .conv_busy_i(cbusy), .cal_busy_i(kbusy),
    .engine_wr_i(ewr), .engine_idx_i(eidx), .engine_data_i(edat),
    .cal_start_o(st_o), .cal_type_o(ctype), .power_mode_o(pm_o),
    .input_range_o(rng_o), .cal_ptr_o(ptr));

  function automatic logic [15:0] st_exp(ctrl_fields_type g, logic v, logic a);
    return {6'h00, g.power_mode, 2'h3, g.input_range_select, v | a,
            g.cal_mode_select, g.cal_select, a};
  endfunction

  function automatic logic [3:0] idx(logic [1:0] s, int j);
    return (s == 2'h2) ? 4'h1 : (s == 2'h3) ? 4'h0 : 4'(j);
  endfunction

  function automatic int len(logic [1:0] s);
    return (s == 2'h0) ? 10 : (s == 2'h1) ? 2 : 1;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ctl_wr(input ctrl_fields_type g, input logic s);
    i_adc_host_model.xfer(1, 1, 0, {6'h00, g.power_mode, g.read_select,
      g.input_range_select, 1'b0, g.cal_mode_select, g.cal_select, s}, q);
  endtask

  // Select a sequence for reading and read it once plus one wrap
  task automatic rd_chk(input logic [1:0] s);
    ctrl_fields_type g;
    g = '0;
    g.read_select = RDSEL_CAL;
    g.cal_select = s;
    ctl_wr(g, 1'b0);
    for (int j = 0; j <= len(s); j++)
    begin
      i_adc_host_model.xfer(0, 0, 0, 16'h0000, q);
      chk(q, {2'h0, calm[idx(s, j % len(s))]});
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #40000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'hA1C315E2));
    foreach (calm[i])
      calm[i] = 14'h0000;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // Status word against control fields and activity levels
    for (int j = 0; j < 6; j++)
    begin
      f = ctrl_fields_type'($urandom);
      f.read_select = RDSEL_STATUS;
      cbusy <= 1'($urandom);
      kbusy <= 1'($urandom);
      ctl_wr(f, 1'b0);
      i_adc_host_model.xfer(0, 0, 0, 16'h0000, q);
      chk(q, st_exp(f, cbusy, kbusy));
      chk({13'h0, pm_o, rng_o}, {13'h0, f.power_mode, f.input_range_select});
    end
    kbusy <= 1'b0;
    // Word writes of every sequence, then readback with wrap
    for (int s = 0; s < 4; s++)
    begin
      f = ctrl_fields_type'($urandom);
      f.read_select = 2'h0;
      f.cal_select = 2'(s);
      ctl_wr(f, 1'b0);
      chk({12'h0, ptr}, {12'h0, idx(2'(s), 0)});
      for (int j = 0; j < len(2'(s)); j++)
      begin
        d = 16'($urandom);
        i_adc_host_model.xfer(1, 0, 0, d, q);
        calm[idx(2'(s), j)] = d[13:0];
      end
      chk({12'h0, ptr}, {12'h0, idx(2'(s), 0)});
      rd_chk(2'(s));
    end
    // Byte mode: pointer moves after the high byte only
    @(posedge clk) bm <= 1'b1;
    f.cal_select = CALSEL_GAIN_OFF;
    ctl_wr(f, 1'b0);
    d = 16'($urandom);
    i_adc_host_model.xfer(1, 0, 0, {8'h00, d[7:0]}, q);
    chk({12'h0, ptr}, 16'h0000);
    i_adc_host_model.xfer(1, 0, 1, {8'h00, d[15:8]}, q);
    chk({12'h0, ptr}, 16'h0001);
    calm[0] = d[13:0];
    f.read_select = RDSEL_CAL;
    ctl_wr(f, 1'b0);
    i_adc_host_model.xfer(0, 0, 0, 16'h0000, q);
    chk(q, {8'h00, calm[0][7:0]});
    i_adc_host_model.xfer(0, 0, 1, 16'h0000, q);
    chk(q, {10'h000, calm[0][13:8]});
    @(posedge clk) bm <= 1'b0;
    // Abandoned write sequence, then a self update
    f = '0;
    ctl_wr(f, 1'b0);
    for (int j = 0; j < 3; j++)
    begin
      d = 16'($urandom);
      i_adc_host_model.xfer(1, 0, 0, d, q);
      calm[j] = d[13:0];
    end
    ctl_wr(f, 1'b0);
    chk({12'h0, ptr}, 16'h0000);
    k = $urandom_range(9, 0);
    @(posedge clk);
    ewr <= 1'b1;
    eidx <= 4'(k);
    edat <= 14'($urandom);
    @(posedge clk) ewr <= 1'b0;
    calm[k] = edat;
    rd_chk(2'h0);
    // Calibration start of every type
    for (int s = 0; s < 8; s++)
    begin
      f = ctrl_fields_type'($urandom);
      {f.cal_mode_select, f.cal_select} = 3'(s);
      n0 = starts;
      ctl_wr(f, 1'b1);
      chk(16'(starts - n0), 16'h0001);
      chk({13'h0, ctype}, 16'(s));
      chk({12'h0, ptr}, {12'h0, idx(f.cal_select, 0)});
    end
    // Conversion result path
    @(posedge clk) cres <= 12'($urandom);
    f = '0;
    ctl_wr(f, 1'b0);
    i_adc_host_model.xfer(0, 0, 0, 16'h0000, q);
    chk(q, {4'h0, cres});
    // Clock enable low: a status-select control write is ignored
    @(posedge clk) ce <= 1'b0;
    i_adc_host_model.xfer(1, 1, 0, 16'h00C0, q);
    @(posedge clk) ce <= 1'b1;
    i_adc_host_model.xfer(0, 0, 0, 16'h0000, q);
    chk(q, {4'h0, cres});
    wrap_up();
  end
endmodule
`default_nettype wire
